// file: src/ctu_top.sv
// charge time edge control: register, source select, edge status
// assumes a classic wishbone master on clk_i and analog parts outside
`timescale 1ns/1ps
`default_nettype none
module ctu_top (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // device state and edge sources
  input wire logic idle_i,
  input wire ctu_pkg::ctu_src_t src_i,
  // analog controls and trigger
  output ctu_pkg::ctu_ana_t ana_o,
  output logic trig_o
);
  import ctu_pkg::*;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [CTU_NUM_ASYNC-1:0] sync1;
    logic [CTU_NUM_ASYNC-1:0] sync2;
    logic bus_phase;
    logic ack;
    logic [31:0] rdata;
    ctu_ana_t ana;
    logic trig;
  } ctu_state_t;

  ctu_state_t st_r;
  ctu_state_t st_nxt;

  // synchronised pins and comparators
  logic [12:0] pin_s;
  logic cmp1_s;
  logic cmp2_s;
  logic [CTU_NUM_EDGES-1:0] lvl;
  logic [CTU_NUM_EDGES-1:0] hit;
  logic [CTU_NUM_EDGES-1:0] mode;
  logic [CTU_NUM_EDGES-1:0] pol;
  logic [3:0] sel1;
  logic [3:0] sel2;
  logic run;
  logic pass;
  logic set1;
  logic set2;
  logic acc;
  logic hit_reg;
  logic do_wr;
  logic [31:0] lane;
  logic [31:0] wr_mask;
  logic [31:0] ctrl_v;

  assign pin_s = st_r.sync2[12:0];
  assign cmp1_s = st_r.sync2[13];
  assign cmp2_s = st_r.sync2[14];
  assign sel1 = st_r.ctrl[CTU_E1_SRC +: 4];
  assign sel2 = st_r.ctrl[CTU_E2_SRC +: 4];
  assign mode = {st_r.ctrl[CTU_E2_SENS], st_r.ctrl[CTU_E1_SENS]};
  assign pol = {st_r.ctrl[CTU_E2_POL], st_r.ctrl[CTU_E1_POL]};

  // edge one source multiplexer
  always_comb begin
    lvl[0] = 1'b0; // reserved code gives no edge
    if (sel1 == CTU_SRC_TIMER) begin
      lvl[0] = src_i.timer;
    end else if (sel1 == CTU_SRC_CMPU) begin
      lvl[0] = src_i.compare_one;
    end else if (sel1 == CTU_SRC_PIN2) begin
      lvl[0] = pin_s[1];
    end else if (sel1 == CTU_SRC_PIN1) begin
      lvl[0] = pin_s[0];
    end else if (sel1 < CTU_E1_CAP1) begin
      lvl[0] = pin_s[2 + 4'(sel1 - CTU_E1_PIN3)]; // pins 3..8
    end else if (sel1 < CTU_SRC_CMP1) begin
      lvl[0] = src_i.capture[2'(sel1 - CTU_E1_CAP1)];
    end else if (sel1 == CTU_SRC_CMP1) begin
      lvl[0] = cmp1_s;
    end else if (sel1 == CTU_SRC_CMP2) begin
      lvl[0] = cmp2_s;
    end
  end

  // edge two source multiplexer
  always_comb begin
    lvl[1] = 1'b0; // reserved code gives no edge
    if (sel2 == CTU_SRC_TIMER) begin
      lvl[1] = src_i.timer;
    end else if (sel2 == CTU_SRC_CMPU) begin
      lvl[1] = src_i.compare_one;
    end else if (sel2 == CTU_SRC_PIN2) begin
      lvl[1] = pin_s[1];
    end else if (sel2 == CTU_SRC_PIN1) begin
      lvl[1] = pin_s[0];
    end else if (sel2 < CTU_E2_CAP1) begin
      lvl[1] = pin_s[8 + 4'(sel2 - CTU_E2_PIN9)]; // pins 9..13
    end else if (sel2 < CTU_E2_BUSCLK) begin
      lvl[1] = src_i.capture[2'(sel2 - CTU_E2_CAP1)];
    end else if (sel2 == CTU_E2_BUSCLK) begin
      lvl[1] = st_r.bus_phase; // bus clock seen as a half-rate square wave
    end else if (sel2 == CTU_SRC_CMP1) begin
      lvl[1] = cmp1_s;
    end else if (sel2 == CTU_SRC_CMP2) begin
      lvl[1] = cmp2_s; // delay generation path
    end
  end

  // one qualifier per edge input
  genvar gi;
  generate
    for (gi = 0; gi < CTU_NUM_EDGES; gi++) begin : g_edge
      ctu_edge_qual u_qual (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .lvl_i(lvl[gi]),
        .edge_mode_i(mode[gi]),
        .rise_i(pol[gi]),
        .hit_o(hit[gi])
      );
    end
  endgenerate

  // unit running: enabled and not halted by idle
  assign run = st_r.ctrl[CTU_ON] & ~(st_r.ctrl[CTU_HALT_IDLE] & idle_i);
  // edges reach status only when passed and running
  assign pass = run & st_r.ctrl[CTU_EDGE_PASS];
  // the reserved code never records, even as an active low level
  assign set1 = pass & hit[0] & (sel1 != CTU_SRC_RSV);
  // ordering holds edge two back until edge one is seen
  assign set2 = pass & hit[1] & (sel2 != CTU_SRC_RSV) &
    (~st_r.ctrl[CTU_ORDER] | st_r.ctrl[CTU_E1_SEEN]);

  // bus decode: one register, other addresses read zero
  assign acc = cyc_i & stb_i & ~st_r.ack;
  assign hit_reg = (adr_i == CTU_CTRL_OFS);
  assign do_wr = cyc_i & stb_i & st_r.ack & we_i & hit_reg;

  // byte lane mask from select lines
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      lane[8*i +: 8] = {8{sel_i[i]}};
    end
  end
  assign wr_mask = lane & CTU_CTRL_WMASK;

  // control register with software write and hardware status set
  always_comb begin
    ctrl_v = st_r.ctrl;
    if (do_wr) begin
      ctrl_v = (st_r.ctrl & ~wr_mask) | (dat_i & wr_mask);
    end
    // a hardware set wins over a same-cycle software clear
    if (set1) begin
      ctrl_v[CTU_E1_SEEN] = 1'b1;
    end
    if (set2) begin
      ctrl_v[CTU_E2_SEEN] = 1'b1;
    end
  end

  // next state
  always_comb begin
    st_nxt = st_r;
    st_nxt.ctrl = ctrl_v & CTU_CTRL_WMASK;
    st_nxt.sync1 = {src_i.cmp_two, src_i.cmp_one, src_i.pin};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.bus_phase = ~st_r.bus_phase;
    st_nxt.ack = acc;
    if (acc) begin
      st_nxt.rdata = hit_reg ? st_r.ctrl : 32'h0000_0000;
    end
    // analog controls follow the register
    st_nxt.ana.unit_on = run;
    st_nxt.ana.charge = run & (ctrl_v[CTU_E1_SEEN] ^ ctrl_v[CTU_E2_SEEN]);
    st_nxt.ana.ground = ctrl_v[CTU_GROUND];
    st_nxt.ana.delay_gen = run & ctrl_v[CTU_DLY_GEN];
    st_nxt.ana.trig_en = ctrl_v[CTU_TRIG_EN];
    st_nxt.ana.trim = ctrl_v[CTU_TRIM +: 6];
    st_nxt.ana.range = ctrl_v[CTU_RANGE +: 2];
    // trigger pulse on each recorded edge two
    st_nxt.trig = set2 & ctrl_v[CTU_TRIG_EN]; // same word as ana.trig_en
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
      st_r.ctrl <= CTU_CTRL_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flops
  assign dat_o = st_r.rdata;
  assign ack_o = st_r.ack;
  assign ana_o = st_r.ana;
  assign trig_o = st_r.trig;
endmodule
`default_nettype wire

// file: src/ctu_pkg.sv
// constants and carrier types for the charge time edge control block
// assumes a single 10 MHz clock and a classic wishbone register slave
package ctu_pkg;
  // register map
  localparam logic [3:0] CTU_CTRL_OFS = 4'h0;
  localparam logic [31:0] CTU_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] CTU_CTRL_WMASK = 32'hfffc_bfff;
  // field positions in charge_time_control
  localparam int CTU_E1_SENS = 31;
  localparam int CTU_E1_POL = 30;
  localparam int CTU_E1_SRC = 26;
  localparam int CTU_E2_SEEN = 25;
  localparam int CTU_E1_SEEN = 24;
  localparam int CTU_E2_SENS = 23;
  localparam int CTU_E2_POL = 22;
  localparam int CTU_E2_SRC = 18;
  localparam int CTU_ON = 15;
  localparam int CTU_HALT_IDLE = 13;
  localparam int CTU_DLY_GEN = 12;
  localparam int CTU_EDGE_PASS = 11;
  localparam int CTU_ORDER = 10;
  localparam int CTU_GROUND = 9;
  localparam int CTU_TRIG_EN = 8;
  localparam int CTU_TRIM = 2;
  localparam int CTU_RANGE = 0;
  localparam int CTU_NUM_EDGES = 2;
  localparam int CTU_NUM_ASYNC = 15;
  // edge source codes
  localparam logic [3:0] CTU_SRC_TIMER = 4'h0;
  localparam logic [3:0] CTU_SRC_CMPU = 4'h1;
  localparam logic [3:0] CTU_SRC_PIN2 = 4'h2;
  localparam logic [3:0] CTU_SRC_PIN1 = 4'h3;
  localparam logic [3:0] CTU_E1_PIN3 = 4'h4;
  localparam logic [3:0] CTU_E1_CAP1 = 4'ha;
  localparam logic [3:0] CTU_E2_PIN9 = 4'h4;
  localparam logic [3:0] CTU_E2_CAP1 = 4'h9;
  localparam logic [3:0] CTU_E2_BUSCLK = 4'hc;
  localparam logic [3:0] CTU_SRC_CMP1 = 4'hd;
  localparam logic [3:0] CTU_SRC_CMP2 = 4'he;
  localparam logic [3:0] CTU_SRC_RSV = 4'hf;

  // edge sources: pins and comparators are asynchronous
  typedef struct packed {
    logic [12:0] pin;
    logic cmp_two;
    logic cmp_one;
    logic [2:0] capture;
    logic compare_one;
    logic timer;
  } ctu_src_t;

  // controls toward the analog current source
  typedef struct packed {
    logic unit_on;
    logic charge;
    logic ground;
    logic delay_gen;
    logic trig_en;
    logic [5:0] trim;
    logic [1:0] range;
  } ctu_ana_t;
endpackage

// file: src/ctu_edge_qual.sv
// edge or level qualifier for one selected edge source
// assumes lvl_i is already synchronous to clk_i
`timescale 1ns/1ps
`default_nettype none
module ctu_edge_qual (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // source and setup
  input wire logic lvl_i,
  input wire logic edge_mode_i,
  input wire logic rise_i,
  // qualified event
  output logic hit_o
);
  typedef struct packed {
    logic prev;
  } ctu_eq_state_t;

  ctu_eq_state_t st_r;
  ctu_eq_state_t st_nxt;

  // remember last level for edge detection
  always_comb begin
    st_nxt = st_r;
    st_nxt.prev = lvl_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // edge mode looks for a transition, level mode for the active level
  always_comb begin
    if (edge_mode_i) begin
      hit_o = rise_i ? (lvl_i & ~st_r.prev) : (~lvl_i & st_r.prev);
    end else begin
      hit_o = (lvl_i == rise_i);
    end
  end
endmodule
`default_nettype wire

// file: dv/ctu_asserts.sv
// port checks for the charge time block: bus answer and analog mirrors
// assumes one clock and a synchronous active high reset
`timescale 1ns/1ps
`default_nettype none
module ctu_asserts (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // wishbone slave
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [3:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  // analog controls and trigger
  input wire ctu_pkg::ctu_ana_t ana_o,
  input wire logic trig_o
);
  import ctu_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a fresh request, and the answer to a read of the control word
  sequence s_req;
    cyc_i && stb_i && !ack_o;
  endsequence
  sequence s_rd;
    ack_o && !we_i && adr_i == 4'h0;
  endsequence
  // bus answer and reserved bits
  a_ack_one: assert property (s_req |=> ack_o)
    else $error("request not answered");
  a_ack_drop: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_rsv_zero: assert property (s_rd |-> dat_o[17:16] == 2'h0 && !dat_o[14])
    else $error("reserved bit reads one");
  // analog controls follow the stored word
  a_trim_copy: assert property (s_rd |-> ana_o.trim == dat_o[7:2])
    else $error("trim differs from register");
  a_range_copy: assert property (s_rd |-> ana_o.range == dat_o[1:0])
    else $error("range differs from register");
  a_ground_copy: assert property (s_rd |-> ana_o.ground == dat_o[9])
    else $error("ground differs from register");
  a_unit_run: assert property (s_rd and dat_o[15] && !dat_o[13] |-> ana_o.unit_on)
    else $error("unit not running");
  a_off_quiet: assert property (!ana_o.unit_on |-> !ana_o.delay_gen && !ana_o.charge)
    else $error("stopped unit still active");
  a_trig_gate: assert property (trig_o |-> ana_o.trig_en)
    else $error("trigger while disabled");
endmodule
bind ctu_top ctu_asserts ctu_asserts_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o),
  .ana_o(ana_o), .trig_o(trig_o));
`default_nettype wire

// file: dv/ctu_src_model.sv
// edge source levels seen by the charge time block
// assumes the bench calls put right after a clock edge
`timescale 1ns/1ps
`default_nettype none
module ctu_src_model (
  // clock
  input wire logic clk_i,
  // source levels
  output ctu_pkg::ctu_src_t src_o
);
  import ctu_pkg::*;
  // all sources rest low until told otherwise
  initial src_o = '0;
  // pin levels move just after an edge
  task automatic put(input logic [12:0] p);
    @(posedge clk_i);
    src_o.pin <= p;
  endtask
  // every source level at once, just after an edge
  task automatic put_src(input ctu_src_t s);
    @(posedge clk_i);
    src_o <= s;
  endtask
endmodule
`default_nettype wire

// file: dv/tb.sv
// register and edge scenarios for the charge time block
// assumes ctu_top, its checker bind and the source model
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin num_errors++; \
  $display("BAD %s exp %h got %h", n, e, s); end end
module tb;
  import ctu_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0, idle_i = 1'b0, ack_o, trig_o;
  logic [3:0] adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, q;
  ctu_ana_t ana_o;
  ctu_src_t src_i;
  int num_errors = 0, checks_done = 0;
  int trig_n = 0, k;
  // source struct bit carrying each code of edge one and edge two; the edge two bus clock code has no source bit and takes bit 0
  int e1_bit[15] = '{0, 1, 8, 7, 9, 10, 11, 12, 13, 14, 2, 3, 4, 5, 6};
  int e2_bit[15] = '{0, 1, 8, 7, 15, 16, 17, 18, 19, 2, 3, 4, 0, 5, 6};
  // count trigger pulses
  always @(posedge clk_i) begin
    if (trig_o === 1'b1) trig_n <= trig_n + 1;
  end
  // 10 MHz clock
  always #50 clk_i = ~clk_i;
  ctu_top ctu_top_inst (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o),
    .ack_o(ack_o), .idle_i(idle_i), .src_i(src_i), .ana_o(ana_o), .trig_o(trig_o));
  ctu_src_model ctu_src_model_inst (.clk_i(clk_i), .src_o(src_i));
  // one classic cycle, held until ack is sampled
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
      input logic [3:0] s);
    {cyc_i, stb_i, we_i, adr_i, sel_i, dat_i} <= {2'b11, w, a, s, d};
    do begin
      @(posedge clk_i);
    end while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0, 4'h0);
    `CHK("ctrl", e, q)
  endtask
  // configure, raise sources, read status, then clear
  task automatic src_chk(input logic [31:0] c, input ctu_src_t p, input logic [31:0] e);
    bus(1'b1, 4'h0, c, 4'hf);
    ctu_src_model_inst.put_src(p);
    repeat (6) @(posedge clk_i);
    rd(4'h0, e);
    ctu_src_model_inst.put_src('0);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
  endtask
  // verdict and end of run
  task automatic test_done();
    if (num_errors == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    test_done();
  end
  // main sequence
  initial begin
    repeat (5) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(4'h0, 32'h0);
    bus(1'b1, 4'h0, 32'hfff8_bfff, 4'hf);
    rd(4'h0, 32'hfff8_bfff);
    rd(4'h4, 32'h0);
    `CHK("ana", 13'h17ff, ana_o)
    idle_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    `CHK("run", 1'b0, ana_o.unit_on)
    idle_i <= 1'b0;
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    bus(1'b1, 4'h0, 32'hffff_ffff, 4'h2);
    // low timer level is active: edge one records, edge two one cycle later
    rd(4'h0, 32'h0100_bf00);
    bus(1'b1, 4'h0, 32'h0, 4'hf);
    for (int c = 0; c <= 14; c++)
      src_chk(32'h403c_8800 | (c << 26), 20'h1 << e1_bit[c], 32'h413c_8800 | (c << 26));
    for (int c = 0; c <= 14; c++)
      src_chk(32'h3c40_8800 | (c << 18), 20'h1 << e2_bit[c], 32'h3e40_8800 | (c << 18));
    src_chk(32'hcc3c_8000, 20'h80, 32'hcc3c_8000);
    bus(1'b1, 4'h0, 32'hccc8_8d00, 4'hf);
    ctu_src_model_inst.put(13'h2);
    repeat (6) @(posedge clk_i);
    rd(4'h0, 32'hccc8_8d00);
    ctu_src_model_inst.put(13'h3);
    repeat (6) @(posedge clk_i);
    rd(4'h0, 32'hcdc8_8d00);
    k = trig_n;
    ctu_src_model_inst.put(13'h1);
    ctu_src_model_inst.put(13'h3);
    repeat (6) @(posedge clk_i);
    rd(4'h0, 32'hcfc8_8d00);
    `CHK("trig", k + 1, trig_n)
    bus(1'b1, 4'h0, 32'hccc8_8d00, 4'hf);
    rd(4'h0, 32'hccc8_8d00);
    test_done();
  end
endmodule
`default_nettype wire
